// *** design/bridge_window_pkg.sv ***
// constants, register layout and carrier types of the bridge window router
// Function
// - memory access inside nonprefetch base..limit goes to secondary port, not prefetchable
// - memory window registers: bits 15:4 writable as A[31:20], bits 3:0 read zero
// - memory window limits compare with A[19:0] taken as all ones
// - prefetchable base compares with low twenty address bits taken as zero
// - memory access inside prefetch base..limit goes to secondary port as prefetchable
// - master abort on secondary drops write data and returns all ones on reads
// - alias filter clear: every I/O access inside I/O window goes to secondary; code sends MDA ports, and VGA ports with VGA bit clear, to hub
// - alias filter set: upper 768 bytes of each 1 KB block go to hub
// - alias filter only touches I/O addresses already inside the I/O window
// - VGA and mono bits clear: VGA and MDA references go to hub
// - VGA bit set: VGA references to secondary, MDA references to hub
// - no fast back-to-back cycles; its enable bit reads zero
// - secondary reset bit reads zero and never resets the secondary bus
// - error forwarding and parity response bits read zero; no error forwarding
// - I/O window limit compares with A[11:0] taken as all ones
package bridge_window_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IO_WINDOW = 8'h1C;
  localparam logic [7:0] IDX_NP_BASE = 8'h20;
  localparam logic [7:0] IDX_NP_LIMIT = 8'h22;
  localparam logic [7:0] IDX_PF_BASE = 8'h24;
  localparam logic [7:0] IDX_PF_LIMIT = 8'h26;
  localparam logic [7:0] IDX_ROUTING_CTRL = 8'h3E;
  localparam logic [7:0] IDX_HUB_CONFIG = 8'h60;
  localparam logic [7:0] IDX_ROUTE_STATUS = 8'h61;

  // reset values
  localparam logic [15:0] RST_IO_WINDOW = 16'h00F0;
  localparam logic [15:0] RST_NP_BASE = 16'hFFF0;
  localparam logic [15:0] RST_NP_LIMIT = 16'h0000;
  localparam logic [15:0] RST_PF_BASE = 16'hFFF0;
  localparam logic [15:0] RST_PF_LIMIT = 16'h0000;
  localparam logic [7:0] RST_ROUTING_CTRL = 8'h00;

  // writable masks
  localparam logic [15:0] WINDOW_MASK = 16'hFFF0;
  localparam logic [15:0] IO_WINDOW_MASK = 16'hF0F0;
  localparam logic [7:0] ROUTING_CTRL_MASK = 8'h0C;

  // routing control and hub config field positions
  localparam int VGA_ROUTE_POS = 3;
  localparam int ISA_FILTER_POS = 2;
  localparam int MONO_PRESENT_POS = 0;

  // status field positions
  localparam int ST_BUSY_POS = 0;
  localparam int ST_ABORT_POS = 4;
  localparam int ST_COUNT_LSB = 8;

  // legacy display ranges
  localparam logic [31:0] VGA_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000B_FFFF;
  localparam logic [31:0] MDA_MEM_LO = 32'h000B_0000;
  localparam logic [31:0] MDA_MEM_HI = 32'h000B_7FFF;
  localparam logic [15:0] VGA_IO_A_LO = 16'h03B0;
  localparam logic [15:0] VGA_IO_A_HI = 16'h03BB;
  localparam logic [15:0] VGA_IO_B_LO = 16'h03C0;
  localparam logic [15:0] VGA_IO_B_HI = 16'h03DF;
  localparam logic [15:0] MDA_IO_LO = 16'h03B4;
  localparam logic [15:0] MDA_IO_HI = 16'h03BF;

  localparam logic [19:0] MB_LOW_ONES = 20'hFFFFF;
  localparam logic [11:0] KB4_LOW_ONES = 12'hFFF;
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    RT_HUB = 2'h0,
    RT_NONPREFETCH = 2'h1,
    RT_PREFETCH = 2'h2,
    RT_IO = 2'h3
  } route_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic is_io;
    logic is_write;
  } cpu_req_t;

  typedef struct packed {
    cpu_req_t req;
    logic prefetch;
  } sec_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic abort;
  } sec_resp_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic aborted;
    logic write_dropped;
  } cpu_resp_t;

  typedef struct packed {
    logic [11:0] np_base;
    logic [11:0] np_limit;
    logic [11:0] pf_base;
    logic [11:0] pf_limit;
    logic [3:0] io_base;
    logic [3:0] io_limit;
    logic vga_route_bit;
    logic isa_alias_filter;
    logic mono_adapter_present;
  } window_cfg_t;

endpackage : bridge_window_pkg

// *** design/route_decode.sv ***
// combinational address decode choosing hub link or secondary port
`timescale 1ns/1ps
module route_decode (
  input bridge_window_pkg::window_cfg_t cfg, // programmed windows
  input bridge_window_pkg::cpu_req_t req, // access to classify
  output bridge_window_pkg::route_t route // chosen path
);

  logic [31:0] a;
  logic np_hit;
  logic pf_hit;
  logic io_hit;
  logic isa_alias;
  logic vga_hit;
  logic mda_hit;

  // window comparisons
  always_comb begin
    a = req.addr;
    np_hit = (a >= {cfg.np_base, 20'h0}) && (a <= {cfg.np_limit, bridge_window_pkg::MB_LOW_ONES});
    pf_hit = (a >= {cfg.pf_base, 20'h0}) && (a <= {cfg.pf_limit, bridge_window_pkg::MB_LOW_ONES});
    io_hit = (a[31:16] == 16'h0000) && (a[15:0] >= {cfg.io_base, 12'h000})
      && (a[15:0] <= {cfg.io_limit, bridge_window_pkg::KB4_LOW_ONES});
    isa_alias = cfg.isa_alias_filter && (a[9:8] != 2'h0);
    if (req.is_io) begin
      vga_hit = (a[31:16] == 16'h0000) && (((a[15:0] >= bridge_window_pkg::VGA_IO_A_LO)
        && (a[15:0] <= bridge_window_pkg::VGA_IO_A_HI)) || ((a[15:0] >= bridge_window_pkg::VGA_IO_B_LO)
        && (a[15:0] <= bridge_window_pkg::VGA_IO_B_HI)));
      mda_hit = (a[31:16] == 16'h0000) && (a[15:0] >= bridge_window_pkg::MDA_IO_LO)
        && (a[15:0] <= bridge_window_pkg::MDA_IO_HI);
    end else begin
      vga_hit = (a >= bridge_window_pkg::VGA_MEM_LO) && (a <= bridge_window_pkg::VGA_MEM_HI);
      mda_hit = (a >= bridge_window_pkg::MDA_MEM_LO) && (a <= bridge_window_pkg::MDA_MEM_HI);
    end
  end

  // priority: legacy display, then windows, else hub
  always_comb begin
    route = bridge_window_pkg::RT_HUB;
    if (vga_hit || mda_hit) begin
      if (cfg.vga_route_bit && !mda_hit) begin
        route = req.is_io ? bridge_window_pkg::RT_IO : bridge_window_pkg::RT_NONPREFETCH;
      end else begin
        route = bridge_window_pkg::RT_HUB;
      end
    end else if (req.is_io) begin
      if (io_hit && !isa_alias) begin
        route = bridge_window_pkg::RT_IO;
      end
    end else if (np_hit) begin
      route = bridge_window_pkg::RT_NONPREFETCH;
    end else if (pf_hit) begin
      route = bridge_window_pkg::RT_PREFETCH;
    end
  end

endmodule : route_decode

// *** design/bridge_window_route.sv ***
// bridge window registers, APB slave and secondary forwarding control
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module bridge_window_route #(
  parameter int COUNT_W = 8 // width of the abort counter
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped word
  input wire logic cpu_req_valid, // processor access offered
  input bridge_window_pkg::cpu_req_t cpu_req, // processor access
  output logic cpu_req_ready, // access taken
  output logic cpu_resp_valid, // secondary completion pulse
  output bridge_window_pkg::cpu_resp_t cpu_resp, // completion data
  output logic hub_req_valid, // hub link request pulse
  output bridge_window_pkg::cpu_req_t hub_req, // request for the hub link
  output logic sec_req_valid, // secondary request
  output bridge_window_pkg::sec_req_t sec_req, // secondary request data
  input wire logic sec_req_ready, // secondary takes request
  input wire logic sec_resp_valid, // secondary completion
  input bridge_window_pkg::sec_resp_t sec_resp // secondary completion data
);

  initial begin
    if (COUNT_W < 1 || COUNT_W > 8) begin
      $error("COUNT_W must lie in 1..8");
    end
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11,
    ST_REPLY = 2'b10
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    logic [15:0] io_window;
    logic [15:0] np_base;
    logic [15:0] np_limit;
    logic [15:0] pf_base;
    logic [15:0] pf_limit;
    logic [7:0] routing_ctrl;
    logic mono_adapter_present;
    logic abort_seen;
    logic [COUNT_W-1:0] abort_count;
    bridge_window_pkg::route_t last_route;
    logic [31:0] prdata;
    logic pslverr;
    logic hub_valid;
    bridge_window_pkg::cpu_req_t hub_req;
    logic sec_valid;
    bridge_window_pkg::sec_req_t sec_req;
    logic resp_valid;
    bridge_window_pkg::cpu_resp_t resp;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  bridge_window_pkg::window_cfg_t cfg;
  bridge_window_pkg::route_t route;
  logic [7:0] word_idx;
  logic setup_phase;
  logic access_wr;

  // merge byte lanes 0 and 1 into a 16-bit register under a writable mask
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    merge16 = ((old & ~(lanes & mask)) | (wd[15:0] & lanes & mask)) & mask;
  endfunction : merge16

  // known register words
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == bridge_window_pkg::IDX_IO_WINDOW) || (idx == bridge_window_pkg::IDX_NP_BASE)
      || (idx == bridge_window_pkg::IDX_NP_LIMIT) || (idx == bridge_window_pkg::IDX_PF_BASE)
      || (idx == bridge_window_pkg::IDX_PF_LIMIT) || (idx == bridge_window_pkg::IDX_ROUTING_CTRL)
      || (idx == bridge_window_pkg::IDX_HUB_CONFIG) || (idx == bridge_window_pkg::IDX_ROUTE_STATUS);
  endfunction : is_mapped

  // decoder configuration from the register fields
  always_comb begin
    cfg.np_base = state_r.np_base[15:4];
    cfg.np_limit = state_r.np_limit[15:4];
    cfg.pf_base = state_r.pf_base[15:4];
    cfg.pf_limit = state_r.pf_limit[15:4];
    cfg.io_base = state_r.io_window[7:4];
    cfg.io_limit = state_r.io_window[15:12];
    cfg.vga_route_bit = state_r.routing_ctrl[bridge_window_pkg::VGA_ROUTE_POS];
    cfg.isa_alias_filter = state_r.routing_ctrl[bridge_window_pkg::ISA_FILTER_POS];
    cfg.mono_adapter_present = state_r.mono_adapter_present;
  end

  route_decode u_decode (
    .cfg(cfg),
    .req(cpu_req),
    .route(route)
  );

  // apb phase decode
  always_comb begin
    word_idx = paddr[9:2];
    setup_phase = psel && !penable;
    access_wr = psel && penable && pwrite && is_mapped(word_idx);
  end

  // next state of the whole block
  always_comb begin
    logic [31:0] rd;
    logic abort_set;
    rd = 32'h0000_0000;
    abort_set = 1'b0;
    state_nxt = state_r;
    state_nxt.hub_valid = 1'b0;
    state_nxt.resp_valid = 1'b0;

    // read data captured in the setup phase, answered in the access phase
    if (setup_phase) begin
      unique case (word_idx)
        bridge_window_pkg::IDX_IO_WINDOW: rd = {16'h0000, state_r.io_window};
        bridge_window_pkg::IDX_NP_BASE: rd = {16'h0000, state_r.np_base};
        bridge_window_pkg::IDX_NP_LIMIT: rd = {16'h0000, state_r.np_limit};
        bridge_window_pkg::IDX_PF_BASE: rd = {16'h0000, state_r.pf_base};
        bridge_window_pkg::IDX_PF_LIMIT: rd = {16'h0000, state_r.pf_limit};
        bridge_window_pkg::IDX_ROUTING_CTRL: rd = {24'h00_0000, state_r.routing_ctrl};
        bridge_window_pkg::IDX_HUB_CONFIG: rd = {31'h0000_0000, state_r.mono_adapter_present};
        bridge_window_pkg::IDX_ROUTE_STATUS: begin
          rd[bridge_window_pkg::ST_BUSY_POS] = (state_r.fsm != ST_IDLE);
          rd[2:1] = state_r.last_route;
          rd[bridge_window_pkg::ST_ABORT_POS] = state_r.abort_seen;
          rd[bridge_window_pkg::ST_COUNT_LSB +: COUNT_W] = state_r.abort_count;
        end
        default: rd = 32'h0000_0000;
      endcase
      state_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
      state_nxt.pslverr = !is_mapped(word_idx);
    end

    // register writes at the completing access edge
    if (access_wr) begin
      unique case (word_idx)
        bridge_window_pkg::IDX_IO_WINDOW:
          state_nxt.io_window = merge16(state_r.io_window, pwdata, pstrb, bridge_window_pkg::IO_WINDOW_MASK);
        bridge_window_pkg::IDX_NP_BASE:
          state_nxt.np_base = merge16(state_r.np_base, pwdata, pstrb, bridge_window_pkg::WINDOW_MASK);
        bridge_window_pkg::IDX_NP_LIMIT:
          state_nxt.np_limit = merge16(state_r.np_limit, pwdata, pstrb, bridge_window_pkg::WINDOW_MASK);
        bridge_window_pkg::IDX_PF_BASE:
          state_nxt.pf_base = merge16(state_r.pf_base, pwdata, pstrb, bridge_window_pkg::WINDOW_MASK);
        bridge_window_pkg::IDX_PF_LIMIT:
          state_nxt.pf_limit = merge16(state_r.pf_limit, pwdata, pstrb, bridge_window_pkg::WINDOW_MASK);
        bridge_window_pkg::IDX_ROUTING_CTRL: begin
          // only the VGA and alias bits hold; reset, abort mode and error bits stay zero
          if (pstrb[0]) begin
            state_nxt.routing_ctrl = pwdata[7:0] & bridge_window_pkg::ROUTING_CTRL_MASK;
          end
        end
        bridge_window_pkg::IDX_HUB_CONFIG: begin
          if (pstrb[0]) begin
            state_nxt.mono_adapter_present = pwdata[bridge_window_pkg::MONO_PRESENT_POS];
          end
        end
        bridge_window_pkg::IDX_ROUTE_STATUS: begin
          // write one clears the sticky abort flag and its counter
          if (pstrb[0] && pwdata[bridge_window_pkg::ST_ABORT_POS]) begin
            state_nxt.abort_seen = 1'b0;
            state_nxt.abort_count = '0;
          end
        end
        default: state_nxt.pslverr = 1'b1;
      endcase
    end

    // forwarding sequence
    unique case (state_r.fsm)
      ST_IDLE: begin
        if (cpu_req_valid) begin
          state_nxt.last_route = route;
          if (route == bridge_window_pkg::RT_HUB) begin
            state_nxt.hub_valid = 1'b1;
            state_nxt.hub_req = cpu_req;
          end else begin
            state_nxt.sec_valid = 1'b1;
            state_nxt.sec_req.req = cpu_req;
            state_nxt.sec_req.prefetch = (route == bridge_window_pkg::RT_PREFETCH);
            state_nxt.fsm = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        // one request at a time, never back to back
        if (sec_req_ready) begin
          state_nxt.sec_valid = 1'b0;
          state_nxt.fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sec_resp_valid) begin
          state_nxt.resp_valid = 1'b1;
          state_nxt.resp.aborted = sec_resp.abort;
          state_nxt.resp.write_dropped = sec_resp.abort && state_r.sec_req.req.is_write;
          state_nxt.resp.rdata = sec_resp.abort ? bridge_window_pkg::ALL_ONES : sec_resp.rdata;
          abort_set = sec_resp.abort;
          state_nxt.fsm = ST_REPLY;
        end
      end
      ST_REPLY: begin
        state_nxt.fsm = ST_IDLE;
      end
    endcase

    // a new abort wins over a clear in the same cycle
    if (abort_set) begin
      state_nxt.abort_seen = 1'b1;
      if (state_nxt.abort_count != {COUNT_W{1'b1}}) begin
        state_nxt.abort_count = state_nxt.abort_count + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
      state_r.fsm <= ST_IDLE;
      state_r.io_window <= bridge_window_pkg::RST_IO_WINDOW;
      state_r.np_base <= bridge_window_pkg::RST_NP_BASE;
      state_r.np_limit <= bridge_window_pkg::RST_NP_LIMIT;
      state_r.pf_base <= bridge_window_pkg::RST_PF_BASE;
      state_r.pf_limit <= bridge_window_pkg::RST_PF_LIMIT;
      state_r.routing_ctrl <= bridge_window_pkg::RST_ROUTING_CTRL;
      state_r.last_route <= bridge_window_pkg::RT_HUB;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs
  assign prdata = state_r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && state_r.pslverr;
  assign cpu_req_ready = (state_r.fsm == ST_IDLE);
  assign cpu_resp_valid = state_r.resp_valid;
  assign cpu_resp = state_r.resp;
  assign hub_req_valid = state_r.hub_valid;
  assign hub_req = state_r.hub_req;
  assign sec_req_valid = state_r.sec_valid;
  assign sec_req = state_r.sec_req;

endmodule : bridge_window_route

// *** tb/sec_device_model.sv ***
// behavioural device on the secondary port with adjustable lag and master abort
`timescale 1ns/1ps
module sec_device_model (
  input wire logic pclk, // core clock
  input wire logic presetn, // reset, active low
  input wire logic sec_req_valid, // request offered
  input bridge_window_pkg::sec_req_t sec_req, // request data
  input wire logic [3:0] lag, // cycles before each answer
  input wire logic fail, // end transfers in master abort
  output logic sec_req_ready, // request taken
  output logic sec_resp_valid, // completion pulse
  output bridge_window_pkg::sec_resp_t sec_resp // completion data
);
  logic [3:0] cnt;
  logic busy;
  logic [31:0] addr;
  // take after lag, answer after lag; idle data toggles so stale values never match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      busy <= 1'b0;
      addr <= 32'h0;
      sec_req_ready <= 1'b0;
      sec_resp_valid <= 1'b0;
      sec_resp <= '0;
    end else begin
      sec_req_ready <= 1'b0;
      sec_resp_valid <= 1'b0;
      sec_resp <= ~sec_resp;
      if (!busy && sec_req_valid && !sec_req_ready) begin
        cnt <= (cnt == lag) ? 4'h0 : cnt + 4'h1;
        if (cnt == lag) begin
          sec_req_ready <= 1'b1;
          busy <= 1'b1;
          addr <= sec_req.req.addr;
        end
      end else if (busy) begin
        cnt <= (cnt == lag) ? 4'h0 : cnt + 4'h1;
        if (cnt == lag) begin
          sec_resp_valid <= 1'b1;
          sec_resp <= '{rdata: fail ? 32'h0BAD_0BAD : addr ^ 32'h5A5A_0000, abort: fail};
          busy <= 1'b0;
        end
      end
    end
  end
endmodule : sec_device_model

// *** tb/bridge_route_monitor.sv ***
// port assertions of the bridge window router
`timescale 1ns/1ps
module bridge_route_monitor #(
  parameter int COUNT_W = 8 // abort counter width
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input logic [31:0] prdata, // apb read data
  input logic pslverr, // apb error
  input wire logic cpu_req_valid, // access offered
  input bridge_window_pkg::cpu_req_t cpu_req, // access
  input logic cpu_req_ready, // access taken
  input logic cpu_resp_valid, // completion
  input bridge_window_pkg::cpu_resp_t cpu_resp, // completion data
  input logic hub_req_valid, // hub request
  input bridge_window_pkg::cpu_req_t hub_req, // hub data
  input logic sec_req_valid, // secondary request
  input bridge_window_pkg::sec_req_t sec_req, // secondary data
  input wire logic sec_req_ready, // secondary takes
  input wire logic sec_resp_valid, // secondary done
  input bridge_window_pkg::sec_resp_t sec_resp // secondary result
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  // apb read in its access phase
  assign rd_acc = psel && penable && !pwrite;
  // processor handshake steps
  sequence take_s;
    cpu_req_valid && cpu_req_ready;
  endsequence
  sequence finish_s;
    !cpu_req_ready ##1 cpu_req_ready;
  endsequence
  win_low_zero_a: assert property (
    rd_acc && paddr[9:5] == 5'h04 |-> prdata[3:0] == 4'h0) else $error("window low bits not zero");
  ctrl_fixed_a: assert property (
    rd_acc && paddr[9:2] == bridge_window_pkg::IDX_ROUTING_CTRL |-> (prdata & 32'hFFFF_FFF3) == 32'h0)
    else $error("fixed control bits not zero");
  unmapped_err_a: assert property (psel && penable && paddr[9:2] == 8'h30 |-> pslverr && prdata == 32'h0)
    else $error("unmapped word not refused");
  one_path_a: assert property (take_s |=> hub_req_valid != sec_req_valid)
    else $error("access not sent to exactly one path");
  req_copy_a: assert property (take_s |=> (hub_req_valid ? hub_req : sec_req.req) == $past(cpu_req))
    else $error("forwarded access differs");
  io_plain_a: assert property (sec_req_valid && sec_req.req.is_io |-> !sec_req.prefetch)
    else $error("io access marked prefetchable");
  sec_hold_a: assert property (sec_req_valid && !sec_req_ready |=> sec_req_valid && $stable(sec_req))
    else $error("secondary request dropped early");
  abort_pass_a: assert property (
    sec_resp_valid && !sec_req_valid && !cpu_req_ready |=> cpu_resp_valid && cpu_resp.aborted == $past(sec_resp.abort))
    else $error("secondary completion not passed on");
  abort_ones_a: assert property (
    cpu_resp_valid && cpu_resp.aborted && !cpu_resp.write_dropped |-> cpu_resp.rdata == 32'hFFFF_FFFF)
    else $error("aborted read not all ones");
  drop_abort_a: assert property (cpu_resp_valid && cpu_resp.write_dropped |-> cpu_resp.aborted)
    else $error("write dropped without abort");
  busy_refuse_a: assert property (sec_req_valid |-> !cpu_req_ready)
    else $error("access taken during transfer");
  resp_release_a: assert property (cpu_resp_valid |-> finish_s)
    else $error("ready not back after completion");
endmodule : bridge_route_monitor

bind bridge_window_route bridge_route_monitor #(.COUNT_W(COUNT_W)) i_bridge_route_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req), .cpu_req_ready(cpu_req_ready),
  .cpu_resp_valid(cpu_resp_valid), .cpu_resp(cpu_resp), .hub_req_valid(hub_req_valid), .hub_req(hub_req),
  .sec_req_valid(sec_req_valid), .sec_req(sec_req), .sec_req_ready(sec_req_ready),
  .sec_resp_valid(sec_resp_valid), .sec_resp(sec_resp));

// *** tb/bridge_window_route_tb.sv ***
// testbench of the bridge window router with a secondary device model
`timescale 1ns/1ps
module bridge_window_route_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fail = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF, lag = 4'h0;
  logic pready, pslverr, err, cpu_req_valid = 1'b0, cpu_req_ready, cpu_resp_valid, hub_req_valid;
  logic sec_req_valid, sec_req_ready, sec_resp_valid;
  bridge_window_pkg::cpu_req_t cpu_req = '0, hub_req;
  bridge_window_pkg::cpu_resp_t cpu_resp;
  bridge_window_pkg::sec_req_t sec_req;
  bridge_window_pkg::sec_resp_t sec_resp;
  int failures = 0, n_tests = 0;
  // route code, is_io, address; codes 0 hub, 1 nonprefetch, 2 prefetch, 3 io
  logic [34:0] plain [13] = '{{2'h1, 1'b0, 32'h1000_0000}, {2'h1, 1'b0, 32'h101F_FFFF},
    {2'h0, 1'b0, 32'h1020_0000}, {2'h0, 1'b0, 32'h0FFF_FFFF}, {2'h2, 1'b0, 32'h2000_0000},
    {2'h2, 1'b0, 32'h20FF_FFFF}, {2'h0, 1'b0, 32'h2100_0000}, {2'h3, 1'b1, 32'h0000_1000},
    {2'h3, 1'b1, 32'h0000_2FFF}, {2'h0, 1'b1, 32'h0000_3000}, {2'h3, 1'b1, 32'h0000_1100},
    {2'h0, 1'b0, 32'h000A_0000}, {2'h0, 1'b1, 32'h0000_03C0}};
  logic [34:0] legacy [7] = '{{2'h1, 1'b0, 32'h000A_0000}, {2'h3, 1'b1, 32'h0000_03C0},
    {2'h0, 1'b0, 32'h000B_0000}, {2'h0, 1'b1, 32'h0000_03B4}, {2'h0, 1'b1, 32'h0000_1100},
    {2'h3, 1'b1, 32'h0000_10FF}, {2'h0, 1'b1, 32'h0000_3000}};
  // 25 MHz clock
  always #20 pclk = ~pclk;
  bridge_window_route #(.COUNT_W(8)) i_bridge_window_route (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req),
    .cpu_req_ready(cpu_req_ready), .cpu_resp_valid(cpu_resp_valid), .cpu_resp(cpu_resp),
    .hub_req_valid(hub_req_valid), .hub_req(hub_req), .sec_req_valid(sec_req_valid), .sec_req(sec_req),
    .sec_req_ready(sec_req_ready), .sec_resp_valid(sec_resp_valid), .sec_resp(sec_resp));
  sec_device_model i_sec_device_model (.pclk(pclk), .presetn(presetn), .sec_req_valid(sec_req_valid),
    .sec_req(sec_req), .lag(lag), .fail(fail), .sec_req_ready(sec_req_ready),
    .sec_resp_valid(sec_resp_valid), .sec_resp(sec_resp));
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    // let an edge pass so a released select is never raised again in the same step
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, e, rd);
  endtask : rchk
  task automatic cpu(input logic [31:0] a, input logic io, input logic wr, input logic [1:0] e);
    logic [1:0] got;
    logic [31:0] ad;
    int k;
    got = 2'bxx;
    ad = 32'hx;
    cpu_req_valid <= 1'b1;
    cpu_req <= '{addr: a, wdata: ~a, is_io: io, is_write: wr};
    k = 0;
    // ready is looked at on the falling edge, where it has settled
    do begin @(negedge pclk); k++; end while (cpu_req_ready !== 1'b1 && k < 50);
    @(posedge pclk);
    cpu_req_valid <= 1'b0;
    k = 0;
    do begin @(negedge pclk); k++; end while (hub_req_valid !== 1'b1 && sec_req_valid !== 1'b1 && k < 4);
    if (sec_req_valid === 1'b1) begin
      got = sec_req.prefetch ? 2'h2 : {io, 1'b1};
      ad = sec_req.req.addr;
      k = 0;
      do begin @(negedge pclk); k++; end while (cpu_resp_valid !== 1'b1 && k < 60);
      chk("completion", 32'({fail, 1'b1}), 32'({cpu_resp.aborted, cpu_resp_valid}));
      chk("dropped", 32'(fail & wr), 32'(cpu_resp.write_dropped));
      if (!wr) chk("read data", fail ? 32'hFFFF_FFFF : a ^ 32'h5A5A_0000, cpu_resp.rdata);
    end else if (hub_req_valid === 1'b1) begin
      got = 2'h0;
      ad = hub_req.addr;
    end
    chk("route", 32'(e), 32'(got));
    chk("address", a, ad);
    @(posedge pclk);
  endtask : cpu
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // cut a hang short
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("np limit", 12'h088, 32'h0);
    rchk("pf base", 12'h090, 32'hFFF0);
    rchk("pf limit", 12'h098, 32'h0);
    rchk("routing ctrl", 12'h0F8, 32'h0);
    apb(1'b1, 12'h088, 32'hFFFF_FFFF);
    rchk("np limit", 12'h088, 32'hFFF0);
    apb(1'b1, 12'h0F8, 32'hFFFF_FFFF);
    rchk("routing ctrl", 12'h0F8, 32'hC);
    apb(1'b1, 12'h0C0, 32'hFFFF_FFFF);
    chk("unmapped err", 32'h1, 32'(err));
    rchk("unmapped", 12'h0C0, 32'h0);
    $display("test registers done");
    apb(1'b1, 12'h0F8, 32'h0);
    apb(1'b1, 12'h080, 32'h1000);
    apb(1'b1, 12'h088, 32'h1010);
    apb(1'b1, 12'h090, 32'h2000);
    apb(1'b1, 12'h098, 32'h20F0);
    apb(1'b1, 12'h070, 32'h2010);
    for (int i = 0; i < 13; i++) cpu(plain[i][31:0], plain[i][32], 1'b0, plain[i][34:33]);
    $display("test windows done");
    apb(1'b1, 12'h0F8, 32'hC);
    apb(1'b1, 12'h180, 32'h1);
    for (int i = 0; i < 7; i++) cpu(legacy[i][31:0], legacy[i][32], 1'b0, legacy[i][34:33]);
    $display("test legacy routes done");
    fail <= 1'b1;
    lag <= 4'h3;
    cpu(32'h1000_0040, 1'b0, 1'b0, 2'h1);
    cpu(32'h1000_0080, 1'b0, 1'b1, 2'h1);
    fail <= 1'b0;
    cpu(32'h2000_0100, 1'b0, 1'b0, 2'h2);
    apb(1'b0, 12'h184, 32'h0);
    chk("sticky abort", 32'h10, rd & 32'h10);
    $display("test abort done");
    summarize();
  end
endmodule : bridge_window_route_tb
